// ### verilog/pfcs_host.sv
// Host-side command sequencer that drives a parallel NOR flash through its pins
`timescale 1ns/1ns
// Contract
// - Host writes with write strobe inside select
// - Host programs single words into erased sectors
// - Program is unlock then address/data cycle
// - Sector/block erase six cycles, 30H/50H last
// - Chip erase six cycles, 10H at 5555H
// - Once status shows done, host rereads twice to confirm
module pfcs_host (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input pfcs_pkg::pfcs_req_s req,
  // User answer
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_error,
  output logic busy,
  // Flash pins
  output logic flash_nce,
  output logic flash_noe,
  output logic flash_nwe,
  output logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe
);
  typedef enum logic [7:0] {
    PFCS_IDLE = 8'b0000_0001,
    PFCS_CMD = 8'b0000_0010,
    PFCS_READ = 8'b0000_0100,
    PFCS_POLL = 8'b0000_1000,
    PFCS_CHECK = 8'b0001_0000,
    PFCS_CONFIRM = 8'b0010_0000,
    PFCS_DONE = 8'b0100_0000,
    PFCS_WAIT = 8'b1000_0000
  } pfcs_st_e;

  pfcs_st_e state_reg;
  pfcs_pkg::pfcs_req_s req_reg;
  logic [2:0] step_reg;
  logic [15:0] prev_reg;
  logic [1:0] confirm_reg;
  logic [23:0] timer_reg;
  logic cyc_start;
  logic cyc_write;
  logic [19:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [15:0] dq_meta_reg;
  logic [15:0] dq_sync_reg;
  pfcs_pkg::pfcs_pins_s pins;
  logic [2:0] last_step;
  logic status_done;

  // Program has a short limit of PROGRAM_CYC cycles; every erase is bounded only by the ceiling parameter
  localparam logic [23:0] PROGRAM_LIMIT = 24'(pfcs_pkg::PROGRAM_CYC);
  localparam logic [23:0] ERASE_LIMIT = 24'hFF_FFFF;

  // Cycle table: unlock pair, then command, then for erase a second unlock pair and the final code
  function automatic logic [35:0] seq_cycle(input pfcs_pkg::pfcs_req_s r, input logic [2:0] step);
    logic [19:0] a;
    logic [15:0] d;
    a = pfcs_pkg::UNLOCK_ADDR_1;
    d = pfcs_pkg::UNLOCK_DATA_1;
    case (step)
      3'd1, 3'd4: begin
        a = pfcs_pkg::UNLOCK_ADDR_2;
        d = pfcs_pkg::UNLOCK_DATA_2;
      end
      3'd2: begin
        d = (r.op == pfcs_pkg::PFCS_OP_PROGRAM) ? pfcs_pkg::CMD_PROGRAM : pfcs_pkg::CMD_ERASE_SETUP;
      end
      3'd3: begin
        if (r.op == pfcs_pkg::PFCS_OP_PROGRAM) begin
          a = r.addr;
          d = r.data;
        end
      end
      3'd5: begin
        case (r.op)
          pfcs_pkg::PFCS_OP_SECTOR: begin
            a = {r.addr[19:pfcs_pkg::SECTOR_LSB], 11'h000};
            d = pfcs_pkg::CMD_SECTOR_ERASE;
          end
          pfcs_pkg::PFCS_OP_BLOCK: begin
            a = {r.addr[19:pfcs_pkg::BLOCK_LSB], 15'h0000};
            d = pfcs_pkg::CMD_BLOCK_ERASE;
          end
          default: begin
            a = pfcs_pkg::CHIP_ERASE_ADDR;
            d = pfcs_pkg::CMD_CHIP_ERASE;
          end
        endcase
      end
      default: begin
        // Plain reads go straight to the requested word
        if (r.op == pfcs_pkg::PFCS_OP_READ) begin
          a = r.addr;
        end
      end
    endcase
    return {a, d};
  endfunction : seq_cycle

  // ==========================================================================
  // Data pins come from outside the clock domain
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dq_meta_reg <= 16'h0000;
      dq_sync_reg <= 16'h0000;
    end else begin
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  pfcs_bus_cycle u_cycle (
    .clock(clock),
    .nrst(nrst),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .dq_sync(dq_sync_reg)
  );

  assign last_step = (req_reg.op == pfcs_pkg::PFCS_OP_PROGRAM) ? 3'd3 : 3'd5;
  assign cyc_write = (state_reg == PFCS_CMD);
  assign cyc_start = (state_reg == PFCS_CMD) || (state_reg == PFCS_READ) || (state_reg == PFCS_POLL)
    || (state_reg == PFCS_CONFIRM);
  assign {cyc_addr, cyc_wdata} = seq_cycle(req_reg, step_reg);
  // Done when the toggle bit stopped and bit 7 shows true data: the written bit for program, one for erase
  assign status_done = (cyc_rdata[pfcs_pkg::ALT_BIT] == prev_reg[pfcs_pkg::ALT_BIT])
    && ((req_reg.op == pfcs_pkg::PFCS_OP_PROGRAM)
      ? (cyc_rdata[pfcs_pkg::INV_DATA_BIT] == req_reg.data[pfcs_pkg::INV_DATA_BIT])
      : cyc_rdata[pfcs_pkg::INV_DATA_BIT]);

  // ==========================================================================
  // Operation sequencing; new requests are held off while the flash is busy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= PFCS_IDLE;
      req_reg <= '{op: pfcs_pkg::PFCS_OP_READ, addr: 20'h0_0000, data: 16'h0000};
      step_reg <= 3'd0;
      prev_reg <= 16'h0000;
      confirm_reg <= 2'd0;
      timer_reg <= 24'h00_0000;
    end else begin
      case (state_reg)
        PFCS_IDLE: begin
          if (req_valid) begin
            req_reg <= req;
            step_reg <= 3'd0;
            state_reg <= (req.op == pfcs_pkg::PFCS_OP_READ) ? PFCS_READ : PFCS_CMD;
          end
        end
        PFCS_READ: begin
          state_reg <= PFCS_WAIT;
        end
        PFCS_CMD: begin
          state_reg <= PFCS_WAIT;
        end
        PFCS_WAIT: begin
          if (cyc_done) begin
            if (req_reg.op == pfcs_pkg::PFCS_OP_READ) begin
              state_reg <= PFCS_DONE;
            end else if (step_reg == last_step) begin
              timer_reg <= 24'h00_0000;
              prev_reg <= ~req_reg.data;
              state_reg <= PFCS_POLL;
            end else begin
              step_reg <= step_reg + 3'd1;
              state_reg <= PFCS_CMD;
            end
          end
        end
        PFCS_POLL, PFCS_CONFIRM: begin
          state_reg <= PFCS_CHECK;
        end
        PFCS_CHECK: begin
          // Saturates so a stuck erase reads as overrun instead of wrapping to zero
          if (timer_reg != ERASE_LIMIT) begin
            timer_reg <= timer_reg + 24'h00_0001;
          end
          if (cyc_done) begin
            prev_reg <= cyc_rdata;
            if (status_done && confirm_reg == 2'(pfcs_pkg::CONFIRM_READS)) begin
              state_reg <= PFCS_DONE;
            end else if (status_done) begin
              confirm_reg <= confirm_reg + 2'd1;
              state_reg <= PFCS_CONFIRM;
            end else begin
              confirm_reg <= 2'd0;
              state_reg <= PFCS_POLL;
            end
          end
        end
        PFCS_DONE: begin
          confirm_reg <= 2'd0;
          state_reg <= PFCS_IDLE;
        end
        default: begin
          state_reg <= PFCS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Answer and timeout reporting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= (state_reg == PFCS_DONE);
      if (state_reg == PFCS_DONE) begin
        rsp_data <= cyc_rdata;
        rsp_error <= (req_reg.op == pfcs_pkg::PFCS_OP_PROGRAM) ? (timer_reg > PROGRAM_LIMIT)
          : (timer_reg == ERASE_LIMIT);
      end
    end
  end

  // Only one operation at a time, so no command is ever sent into a busy flash
  assign req_ready = (state_reg == PFCS_IDLE);
  assign busy = (state_reg != PFCS_IDLE);
  assign flash_nce = pins.nce;
  assign flash_noe = pins.noe;
  assign flash_nwe = pins.nwe;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe = pins.dq_oe;
endmodule : pfcs_host

// ### verilog/pfcs_pkg.sv
// Package with constants and carrier types for the parallel flash host sequencer
package pfcs_pkg;
  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // ==========================================================================
  // Command codes and unlock cycles (customary unlock values, held as parameters)
  localparam logic [19:0] UNLOCK_ADDR_1 = 20'h0_5555;
  localparam logic [19:0] UNLOCK_ADDR_2 = 20'h0_2AAA;
  localparam logic [15:0] UNLOCK_DATA_1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA_2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0050;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [19:0] CHIP_ERASE_ADDR = 20'h0_5555;
  // ==========================================================================
  // Region geometry: sector is 2K words, block is 32K words
  localparam int SECTOR_LSB = 11;
  localparam int BLOCK_LSB = 15;
  // ==========================================================================
  // Status bit positions
  localparam int INV_DATA_BIT = 7;
  localparam int ALT_BIT = 6;
  // ==========================================================================
  // Timing at 20 MHz
  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_NS = 150;
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_US = 20;
  localparam int PROGRAM_CYC = (PROGRAM_US * 1000) / CLK_NS;
  localparam int CONFIRM_READS = 2;
  localparam int TIMER_W = 24;
  // ==========================================================================
  // Operation codes
  typedef enum logic [2:0] {
    PFCS_OP_READ = 3'h0,
    PFCS_OP_PROGRAM = 3'h1,
    PFCS_OP_SECTOR = 3'h2,
    PFCS_OP_BLOCK = 3'h3,
    PFCS_OP_CHIP = 3'h4
  } pfcs_op_e;
  typedef struct packed {
    pfcs_op_e op;
    logic [19:0] addr;
    logic [15:0] data;
  } pfcs_req_s;
  typedef struct packed {
    logic nce;
    logic noe;
    logic nwe;
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } pfcs_pins_s;
endpackage : pfcs_pkg

// ### verilog/pfcs_bus_cycle.sv
// Single bus cycle engine: one write or one read on the flash pins
`timescale 1ns/1ns
module pfcs_bus_cycle (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Cycle request
  input wire logic start,
  input wire logic is_write,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // Flash pins
  output pfcs_pkg::pfcs_pins_s pins,
  input wire logic [15:0] dq_sync
);
  typedef enum logic [3:0] {
    PFCS_BC_IDLE = 4'b0001,
    PFCS_BC_SETUP = 4'b0010,
    PFCS_BC_STROBE = 4'b0100,
    PFCS_BC_HOLD = 4'b1000
  } pfcs_bc_e;
  pfcs_bc_e state_reg;
  logic [3:0] cnt_reg;
  logic write_reg;
  localparam logic [3:0] STROBE_LEN = 4'(pfcs_pkg::STROBE_CYC);
  // Read strobe is held longer since data passes two sync stages on the way in
  localparam logic [3:0] READ_LEN = 4'(pfcs_pkg::READ_CYC + 2);

  // ==========================================================================
  // Cycle sequencing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= PFCS_BC_IDLE;
      cnt_reg <= 4'h0;
      write_reg <= 1'b0;
    end else begin
      case (state_reg)
        PFCS_BC_IDLE: begin
          if (start) begin
            state_reg <= PFCS_BC_SETUP;
            write_reg <= is_write;
          end
        end
        PFCS_BC_SETUP: begin
          state_reg <= PFCS_BC_STROBE;
          cnt_reg <= 4'h0;
        end
        PFCS_BC_STROBE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == (write_reg ? STROBE_LEN : READ_LEN) - 4'h1) begin
            state_reg <= PFCS_BC_HOLD;
          end
        end
        PFCS_BC_HOLD: begin
          state_reg <= PFCS_BC_IDLE;
        end
        default: begin
          state_reg <= PFCS_BC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin drive: chip select spans setup to hold so write strobe edges fall inside it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pins <= '{nce: 1'b1, noe: 1'b1, nwe: 1'b1, addr: 20'h0_0000, dq_out: 16'h0000, dq_oe: 1'b0};
    end else begin
      case (state_reg)
        PFCS_BC_IDLE: begin
          pins.nce <= ~start;
          pins.noe <= 1'b1;
          pins.nwe <= 1'b1;
          pins.dq_oe <= 1'b0;
          if (start) begin
            pins.addr <= addr;
            pins.dq_out <= wdata;
          end
        end
        PFCS_BC_SETUP: begin
          pins.nwe <= ~write_reg;
          pins.noe <= write_reg;
          pins.dq_oe <= write_reg;
        end
        PFCS_BC_STROBE: begin
          if (cnt_reg == (write_reg ? STROBE_LEN : READ_LEN) - 4'h1) begin
            pins.nwe <= 1'b1;
            pins.noe <= 1'b1;
          end
        end
        PFCS_BC_HOLD: begin
          pins.nce <= 1'b1;
          pins.dq_oe <= 1'b0;
        end
        default: begin
          pins.nce <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read capture just before output gate rises
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (state_reg == PFCS_BC_STROBE && !write_reg && cnt_reg == READ_LEN - 4'h1) begin
      rdata <= dq_sync;
    end
  end

  assign done = (state_reg == PFCS_BC_HOLD);
endmodule : pfcs_bus_cycle

// ### sim/pfcs_flash_model.sv
// Behavioural model of the parallel NOR flash that the host sequencer drives
`timescale 1ns/1ns
module pfcs_flash_model #(
  parameter int PROG_NS = 5000,
  parameter int ERASE_NS = 10000
) (
  // Flash pins
  input wire logic nce,
  input wire logic noe,
  input wire logic nwe,
  input wire logic [19:0] addr,
  input wire logic [15:0] host_dq,
  input wire logic host_oe,
  output logic [15:0] dq_bus,
  // Observation
  output logic [7:0] n_ops,
  output logic [7:0] n_bad
);
  logic [15:0] mem [logic [19:0]];
  logic [19:0] lat_addr;
  logic [19:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] last;
  logic op_busy;
  logic alt;
  logic armed;
  logic low_power;
  int step;
  int kind;
  event op_go;
  initial begin
    {op_busy, alt, armed, low_power, n_ops, n_bad, last} = '0;
    step = 0;
    kind = 0;
  end
  function automatic logic [15:0] array_word(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : array_word
  // ==========================================================================
  // Command cycles
  task automatic cmd_cycle(input logic [19:0] a, input logic [15:0] d);
    logic ok;
    if (op_busy) return;
    case (step)
      0: ok = a == pfcs_pkg::UNLOCK_ADDR_1 && d == pfcs_pkg::UNLOCK_DATA_1;
      1: ok = a == pfcs_pkg::UNLOCK_ADDR_2 && d == pfcs_pkg::UNLOCK_DATA_2;
      2: begin
        ok = a == pfcs_pkg::UNLOCK_ADDR_1 && (d == pfcs_pkg::CMD_PROGRAM || d == pfcs_pkg::CMD_ERASE_SETUP);
        kind = d == pfcs_pkg::CMD_PROGRAM ? 1 : 0;
      end
      3: ok = kind == 1 || (a == pfcs_pkg::UNLOCK_ADDR_1 && d == pfcs_pkg::UNLOCK_DATA_1);
      4: ok = a == pfcs_pkg::UNLOCK_ADDR_2 && d == pfcs_pkg::UNLOCK_DATA_2;
      default: begin
        ok = d == pfcs_pkg::CMD_SECTOR_ERASE || d == pfcs_pkg::CMD_BLOCK_ERASE ||
             (d == pfcs_pkg::CMD_CHIP_ERASE && a == pfcs_pkg::CHIP_ERASE_ADDR);
        kind = d == pfcs_pkg::CMD_SECTOR_ERASE ? 2 : d == pfcs_pkg::CMD_BLOCK_ERASE ? 3 : 4;
      end
    endcase
    if (!ok) begin
      step = 0;
      n_bad++;
    end else if ((step == 3 && kind == 1) || step == 5) begin
      step = 0;
      wr_addr = a;
      wr_data = d;
      op_busy = 1'b1;
      n_ops++;
      ->op_go;
    end else begin
      step++;
    end
  endtask : cmd_cycle
  always @(negedge nwe or negedge nce) begin
    if (!nwe && !nce) lat_addr = addr;
  end
  // Whichever strobe rises first still sees the other low
  always @(posedge nwe or posedge nce) begin
    if (nwe !== nce) cmd_cycle(lat_addr, host_dq);
  end
  // ==========================================================================
  // Internal operations, the array only loses bits when programmed
  always @(op_go) begin
    #(kind == 1 ? PROG_NS : ERASE_NS);
    if (kind == 1) mem[wr_addr] = array_word(wr_addr) & wr_data;
    else if (kind == 4) mem.delete();
    else foreach (mem[k]) begin
      if ((k >> (kind == 2 ? 11 : 15)) == (wr_addr >> (kind == 2 ? 11 : 15))) mem[k] = 16'hFFFF;
    end
    op_busy = 1'b0;
  end
  // ==========================================================================
  // Reads and status
  always @(negedge noe) begin
    if (op_busy && !nce) alt = ~alt;
  end
  // Low power never costs access time, so it only shows as a flag
  always @(addr or negedge nce) begin
    armed = 1'b1;
    low_power = 1'b0;
  end
  always @(posedge noe) low_power = armed;
  // Floating bus shows the inverse of the last value so it never looks valid
  always @(nce or noe or nwe or addr or op_busy or alt or host_oe or host_dq) begin
    if (host_oe) begin
      dq_bus = host_dq;
      last = dq_bus;
    end else if (!nce && !noe) begin
      if (op_busy) dq_bus = {8'h00, kind == 1 ? ~wr_data[7] : 1'b0, alt, 6'h00};
      else dq_bus = array_word(addr);
      last = dq_bus;
    end else begin
      dq_bus = ~last;
    end
  end
endmodule : pfcs_flash_model

// ### sim/pfcs_host_assertions.sv
// Concurrent checks on the ports of the parallel flash host sequencer
`timescale 1ns/1ns
module pfcs_host_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // User side
  input wire logic req_valid,
  input wire logic req_ready,
  input pfcs_pkg::pfcs_req_s req,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_error,
  input wire logic busy,
  // Flash pins
  input wire logic flash_nce,
  input wire logic flash_noe,
  input wire logic flash_nwe,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [3:0] we_cnt_reg;
  pfcs_pkg::pfcs_op_e op_reg;
  // ==========================================================================
  // Write pulses counted per request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      we_cnt_reg <= 4'h0;
      op_reg <= pfcs_pkg::PFCS_OP_READ;
    end else if (req_valid && req_ready) begin
      we_cnt_reg <= 4'h0;
      op_reg <= req.op;
    end else if ($fell(flash_nwe)) begin
      we_cnt_reg <= we_cnt_reg + 4'h1;
    end
  end
  // ==========================================================================
  // Assertions
  we_in_ce_a: assert property (!flash_nwe |-> !flash_nce)
    else $error("write strobe outside select");
  bus_fight_a: assert property (flash_dq_oe |-> flash_noe)
    else $error("host drives data while output gate low");
  write_hold_a: assert property (!flash_nwe && !$past(flash_nwe) |->
    $stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe) else $error("write cycle not held");
  we_pulse_a: assert property ($fell(flash_nwe) |=> !flash_nwe ##1 flash_nwe)
    else $error("write pulse width wrong");
  data_at_rise_a: assert property ($rose(flash_nwe) |-> flash_dq_oe && !flash_nce && $stable(flash_dq_out))
    else $error("data not held through write strobe rise");
  read_gate_a: assert property ($fell(flash_noe) |-> (!flash_noe && !flash_nce)[*5] ##1 flash_noe)
    else $error("read gate window wrong");
  idle_pins_a: assert property (!busy |-> flash_nce && flash_noe && flash_nwe && !flash_dq_oe)
    else $error("pins active while idle");
  pulse_count_a: assert property (rsp_valid |-> we_cnt_reg == (op_reg == pfcs_pkg::PFCS_OP_READ ? 4'h0 :
    op_reg == pfcs_pkg::PFCS_OP_PROGRAM ? 4'h4 : 4'h6)) else $error("wrong number of write cycles");
  prog_time_a: assert property (rsp_valid && op_reg == pfcs_pkg::PFCS_OP_PROGRAM |-> !rsp_error)
    else $error("program reported overrun");
  answer_once_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("answer not a single pulse");
  cover property (rsp_valid && op_reg == pfcs_pkg::PFCS_OP_PROGRAM);
  cover property (rsp_valid && op_reg == pfcs_pkg::PFCS_OP_SECTOR);
  cover property (rsp_valid && op_reg == pfcs_pkg::PFCS_OP_BLOCK);
  cover property (rsp_valid && op_reg == pfcs_pkg::PFCS_OP_CHIP);
endmodule : pfcs_host_assertions
bind pfcs_host pfcs_host_assertions pfcs_host_assertions_i (.clock(clock), .nrst(nrst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
  .busy(busy), .flash_nce(flash_nce), .flash_noe(flash_noe), .flash_nwe(flash_nwe), .flash_addr(flash_addr),
  .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));

// ### sim/testbench.sv
// Self-checking testbench for the parallel flash host sequencer
`timescale 1ns/1ns
module testbench;
  logic clock;
  logic nrst;
  logic req_valid;
  logic req_ready;
  pfcs_pkg::pfcs_req_s req;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic rsp_error;
  logic busy;
  logic flash_nce;
  logic flash_noe;
  logic flash_nwe;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq;
  logic [15:0] flash_dq_out;
  logic flash_dq_oe;
  logic [7:0] n_ops;
  logic [7:0] n_bad;
  int n_mismatch;
  int checks;
  always #25 clock = ~clock;
  pfcs_host pfcs_host_i (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error), .busy(busy), .flash_nce(flash_nce),
    .flash_noe(flash_noe), .flash_nwe(flash_nwe), .flash_addr(flash_addr), .flash_dq_in(flash_dq),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
  pfcs_flash_model pfcs_flash_model_i (.nce(flash_nce), .noe(flash_noe), .nwe(flash_nwe), .addr(flash_addr),
    .host_dq(flash_dq_out), .host_oe(flash_dq_oe), .dq_bus(flash_dq), .n_ops(n_ops), .n_bad(n_bad));
  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  // Waits are bounded so a stuck sequencer ends the run with a verdict
  task automatic run(input pfcs_pkg::pfcs_op_e op, input logic [19:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    logic [7:0] ops0;
    ops0 = n_ops;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, data: d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1) begin
      check(1'b0, "request not taken");
      test_done();
    end
    do begin
      @(posedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 5000);
    if (rsp_valid !== 1'b1) begin
      check(1'b0, "request timed out");
      test_done();
    end
    q = rsp_data;
    check(rsp_error === 1'b0, "error reported");
    check(n_ops === ops0 + (op == pfcs_pkg::PFCS_OP_READ ? 8'h00 : 8'h01), "operation count wrong");
    check(n_bad === 8'h00, "flash saw a broken sequence");
  endtask : run
  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    logic [15:0] q;
    run(pfcs_pkg::PFCS_OP_READ, a, 16'h0000, q);
    check(q === exp, "read data wrong");
  endtask : rd
  task automatic wr(input pfcs_pkg::pfcs_op_e op, input logic [19:0] a, input logic [15:0] d);
    logic [15:0] q;
    run(op, a, d, q);
    // Last poll shows true data: the written word, or all ones after an erase
    check(q === (op == pfcs_pkg::PFCS_OP_PROGRAM ? d : 16'hFFFF), "final status read wrong");
  endtask : wr
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check(flash_nce === 1'b1 && flash_noe === 1'b1 && flash_nwe === 1'b1, "strobes active after reset");
    check(flash_dq_oe === 1'b0 && req_ready === 1'b1 && busy === 1'b0, "bus or ready wrong after reset");
    rd(20'h0_1234, 16'hFFFF);
  endtask : t_reset
  task automatic t_program();
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_1234, 16'h5A3C);
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_1235, 16'h00A5);
    rd(20'h0_1234, 16'h5A3C);
    rd(20'h0_1235, 16'h00A5);
  endtask : t_program
  task automatic t_sector();
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_07FF, 16'h1111);
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_0800, 16'h2222);
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_0FFF, 16'h3333);
    wr(pfcs_pkg::PFCS_OP_SECTOR, 20'h0_0A5A, 16'h0000);
    rd(20'h0_07FF, 16'h1111);
    rd(20'h0_0800, 16'hFFFF);
    rd(20'h0_0FFF, 16'hFFFF);
  endtask : t_sector
  task automatic t_block();
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_7FFF, 16'h4444);
    wr(pfcs_pkg::PFCS_OP_PROGRAM, 20'h0_8000, 16'h5555);
    wr(pfcs_pkg::PFCS_OP_BLOCK, 20'h0_C321, 16'h0000);
    rd(20'h0_7FFF, 16'h4444);
    rd(20'h0_8000, 16'hFFFF);
  endtask : t_block
  task automatic t_chip();
    wr(pfcs_pkg::PFCS_OP_CHIP, 20'h0_0000, 16'h0000);
    rd(20'h0_7FFF, 16'hFFFF);
    rd(20'h0_1234, 16'hFFFF);
  endtask : t_chip
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_program();
    t_sector();
    t_block();
    t_chip();
    check(n_ops === 8'h0A, "total operation count wrong");
    test_done();
  end
endmodule : testbench
